/* common/fcr_consts.svh */
/*
 feature configuration registers: offsets, field positions, reset values
 and fixed counts used by the register bank; its link crossing uses none of them.
 assumes it is included by bare name after the package has been compiled.
*/
`ifndef FCR_CONSTS_SVH
`define FCR_CONSTS_SVH

// register offsets seen by the serial front end
`define FCR_ADDR_DATA_FIRST 8'h02
`define FCR_ADDR_X_LO 8'h02
`define FCR_ADDR_X_HI 8'h03
`define FCR_ADDR_Y_LO 8'h04
`define FCR_ADDR_Y_HI 8'h05
`define FCR_ADDR_Z_LO 8'h06
`define FCR_ADDR_Z_HI 8'h07
`define FCR_ADDR_STATUS_1 8'h08
`define FCR_ADDR_STATUS_2 8'h09
`define FCR_ADDR_IFC 8'h0D
`define FCR_ADDR_FTC 8'h0E

// burst wrap points
`define FCR_WRAP_AT_DATA 8'h07
`define FCR_WRAP_AT_STATUS 8'h09

// interface_feature_control fields
`define FCR_IFC_FOUR_WIRE_SEL 7
`define FCR_IFC_TWO_WIRE_SEL 6
`define FCR_IFC_THREE_WIRE 5
`define FCR_IFC_REARM_ON_CLEAR 4
`define FCR_IFC_FREEZE 3
`define FCR_IFC_WRITE_MASK 8'hF8

// fifo_trigger_feature_control fields
`define FCR_FTC_EXTERNAL_TRIGGER_ENABLE 7
`define FCR_FTC_TRIG_EDGE 6
`define FCR_FTC_STREAM 5
`define FCR_FTC_WRITE_TO_CLEAR 4
`define FCR_FTC_FIFO_TOKEN 3
`define FCR_FTC_SPI_TOKEN 2
`define FCR_FTC_FIFO_BURST 1
`define FCR_FTC_WRAP_SEL 0

// reset values
`define FCR_IFC_RESET 8'h00
`define FCR_FTC_RESET 8'h00

// fifo depth in six-byte groups
`define FCR_FIFO_DEPTH 32

`endif

/* common/fcr_pkg.sv */
/*
 types of the feature configuration register bank: link commands,
 link handshake states and the state records of both clock domains.
 assumes nothing beyond a SystemVerilog compiler.
*/
package fcr_pkg;

   // command kinds passed from the serial front end
   typedef enum logic [1:0] {
      FCR_CMD_START = 2'b00,
      FCR_CMD_WRITE = 2'b01,
      FCR_CMD_READ = 2'b10,
      FCR_CMD_END = 2'b11
   } fcr_cmd_t;

   // link side handshake states, one-hot
   typedef enum logic [1:0] {
      FCR_LK_IDLE = 2'b01,
      FCR_LK_WAIT = 2'b10
   } fcr_lk_state_t;

   // link clock domain state
   typedef struct packed {
      fcr_lk_state_t state;
      logic busy;
      logic req_tgl;
      logic ack_s1;
      logic ack_s2;
      logic ack_s3;
      fcr_cmd_t kind;
      logic [7:0] data;
      logic [7:0] rdata;
      logic rvalid;
   } fcr_lk_t;

   // mclk half of the crossing
   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic req_s3;
      logic ack_tgl;
      logic [7:0] rdata_hold;
      logic cmd_valid;
      fcr_cmd_t cmd_kind;
      logic [7:0] cmd_data;
   } fcr_mc_t;

   // register bank state
   typedef struct packed {
      logic [7:0] ifc;
      logic [7:0] ftc;
      logic [2:0] eff;
      logic [7:0] addr;
      logic [5:0] grp;
      logic in_txn;
      logic done;
      logic [7:0] rdata;
      logic strap_s1;
      logic strap_s2;
      logic trig_s1;
      logic trig_s2;
      logic trig_s3;
      logic mode_d;
      logic flag_d;
      logic halted;
      logic rearm;
      logic clr;
      logic advance;
      logic ext_trig;
      logic store_en;
      logic i2c_en;
      logic spi_en;
      logic three_w;
      logic tok_en;
      logic [7:0] stat_byte;
      logic cap_en;
      logic overwrite;
      logic accept;
      logic int_oe;
      logic int_out;
      logic [15:0] zword;
   } fcr_core_t;

endpackage

/* verilog/fcr_link.sv */
/*
 link crossing: takes one command at a time from the serial front end on
 the link clock and hands it to mclk by a toggle handshake; read data comes
 back the same way.
 assumes the front end is on link_clk, holds off while lk_busy is high, and
 that the core answers each cmd_valid with one cmd_done pulse.
*/
`timescale 1ns/100ps
module fcr_link
   import fcr_pkg::*;
(
   // clocks and reset
   input wire logic link_clk,
   input wire logic mclk,
   input wire logic reset,
   // link side
   input wire logic lk_req,
   input wire fcr_cmd_t lk_kind,
   input wire logic [7:0] lk_data,
   output logic lk_busy,
   output logic [7:0] lk_rdata,
   output logic lk_rvalid,
   // core side
   output logic cmd_valid,
   output fcr_cmd_t cmd_kind,
   output logic [7:0] cmd_data,
   input wire logic cmd_done,
   input wire logic [7:0] cmd_rdata
);

   fcr_lk_t l, nxt_l;
   fcr_mc_t m, nxt_m;

   // link domain: payload stays put while waiting, so mclk may sample it
   always_comb
   begin
      nxt_l = l;
      nxt_l.rvalid = 1'b0;
      nxt_l.ack_s1 = m.ack_tgl;
      nxt_l.ack_s2 = l.ack_s1;
      nxt_l.ack_s3 = l.ack_s2;
      unique case (l.state)
         FCR_LK_IDLE:
         begin
            if (lk_req)
            begin
               nxt_l.kind = lk_kind;
               nxt_l.data = lk_data;
               nxt_l.req_tgl = ~l.req_tgl;
               nxt_l.state = FCR_LK_WAIT;
               nxt_l.busy = 1'b1;
            end
         end
         FCR_LK_WAIT:
         begin
            if (l.ack_s2 != l.ack_s3)
            begin
               nxt_l.rdata = m.rdata_hold; // held since the ack toggled
               nxt_l.rvalid = 1'b1;
               nxt_l.state = FCR_LK_IDLE;
               nxt_l.busy = 1'b0;
            end
         end
         default:
         begin
            nxt_l.state = FCR_LK_IDLE;
            nxt_l.busy = 1'b0;
         end
      endcase
   end

   // link domain registers
   always_ff @(posedge link_clk or posedge reset)
   begin
      if (reset)
         l <= '{state: FCR_LK_IDLE, kind: FCR_CMD_START, default: '0};
      else
         l <= nxt_l;
   end

   // mclk domain: detect the request toggle, answer with the ack toggle
   always_comb
   begin
      nxt_m = m;
      nxt_m.req_s1 = l.req_tgl;
      nxt_m.req_s2 = m.req_s1;
      nxt_m.req_s3 = m.req_s2;
      nxt_m.cmd_valid = (m.req_s2 != m.req_s3);
      if (m.req_s2 != m.req_s3)
      begin
         nxt_m.cmd_kind = l.kind;
         nxt_m.cmd_data = l.data;
      end
      if (cmd_done)
      begin
         nxt_m.rdata_hold = cmd_rdata;
         nxt_m.ack_tgl = ~m.ack_tgl;
      end
   end

   // mclk domain registers
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         m <= '{cmd_kind: FCR_CMD_START, default: '0};
      else
         m <= nxt_m;
   end

   assign lk_busy = l.busy;
   assign lk_rdata = l.rdata;
   assign lk_rvalid = l.rvalid;
   assign cmd_valid = m.cmd_valid;
   assign cmd_kind = m.cmd_kind;
   assign cmd_data = m.cmd_data;

endmodule // fcr_link

/* verilog/fcr_feature_regs.sv */
/*
 feature configuration register bank: the interface feature control and the
 fifo / trigger feature control registers, the burst address counter, the
 interrupt clearing decision, sniff re-arm, fifo capture steering, fifo
 status token formatting and the external trigger input.
 assumes a serial front end on link_clk issuing start / write / read / end
 commands, and sampling, fifo and status logic on mclk around it.
*/
`timescale 1ns/100ps
`include "fcr_consts.svh"

module fcr_feature_regs
   import fcr_pkg::*;
#(
   parameter int FIFO_DEPTH = `FCR_FIFO_DEPTH
)
(
   // clocks and reset
   input wire logic mclk,
   input wire logic reset,
   input wire logic link_clk,
   // serial front end, link clock domain
   input wire logic lk_req,
   input wire fcr_cmd_t lk_kind,
   input wire logic [7:0] lk_data,
   output logic lk_busy,
   output logic [7:0] lk_rdata,
   output logic lk_rvalid,
   // pins
   input wire logic host_is_spi_pin,
   input wire logic int_pin_in,
   output logic int_pin_out,
   output logic int_pin_oe,
   // sample and status inputs
   input wire logic [15:0] x_sample_output,
   input wire logic [15:0] y_sample_output,
   input wire logic [15:0] z_sample_output,
   input wire logic [7:0] status_1,
   input wire logic [7:0] status_2,
   input wire logic res_ge14,
   input wire logic interrupt_pending_flag,
   input wire logic fifo_level_reached_flag,
   input wire logic fifo_full,
   input wire logic fifo_empty,
   input wire logic fifo_enabled,
   // sniff inputs
   input wire logic sniff_while_awake_mode,
   input wire logic sniff_awake_event_flag,
   // register values
   output logic [7:0] interface_feature_control,
   output logic [7:0] fifo_trigger_feature_control,
   // interface steering
   output logic sample_store_enable,
   output logic i2c_comm_enable,
   output logic spi_comm_enable,
   output logic three_wire_select,
   output logic spi_token_enable,
   output logic [7:0] spi_token_byte,
   // fifo steering
   output logic fifo_capture_enable,
   output logic fifo_overwrite_oldest,
   output logic fifo_accept_new,
   output logic fifo_advance,
   output logic [15:0] z_fifo_word,
   // events
   output logic interrupt_clear,
   output logic sniff_halted,
   output logic sniff_rearm,
   output logic ext_trigger
);

   fcr_core_t c, nxt_c;
   logic cmd_valid;
   fcr_cmd_t cmd_kind;
   logic [7:0] cmd_data;

   // edge of a sampled level, rising or falling as asked
   function automatic logic fcr_edge(input logic now, input logic prev, input logic rising);
      return rising ? (now & ~prev) : (~now & prev);
   endfunction

   // z word with the optional fifo status token
   function automatic logic [15:0] fcr_fmt_z(input logic [15:0] z, input logic tok,
                                             input logic hi_res, input logic [3:0] flags);
      logic [15:0] w;
      w = z;
      if (tok && !hi_res)
         w = {flags, z[11:0]};
      else if (tok)
         w = {z[15:4], flags};
      return w;
   endfunction

   // read multiplexer; unmapped offsets read as zero
   function automatic logic [7:0] fcr_pick(input logic [7:0] a, input logic [15:0] x,
                                           input logic [15:0] y, input logic [15:0] z,
                                           input logic [7:0] s1, input logic [7:0] s2,
                                           input logic [7:0] ifc, input logic [7:0] ftc);
      logic [7:0] b;
      b = 8'h00;
      unique case (a)
         `FCR_ADDR_X_LO: b = x[7:0];
         `FCR_ADDR_X_HI: b = x[15:8];
         `FCR_ADDR_Y_LO: b = y[7:0];
         `FCR_ADDR_Y_HI: b = y[15:8];
         `FCR_ADDR_Z_LO: b = z[7:0];
         `FCR_ADDR_Z_HI: b = z[15:8];
         `FCR_ADDR_STATUS_1: b = s1;
         `FCR_ADDR_STATUS_2: b = s2;
         `FCR_ADDR_IFC: b = ifc;
         `FCR_ADDR_FTC: b = ftc;
         default: b = 8'h00;
      endcase
      return b;
   endfunction

   // crossing between the serial front end and this bank
   fcr_link fcr_link_i (
      .link_clk(link_clk),
      .mclk(mclk),
      .reset(reset),
      .lk_req(lk_req),
      .lk_kind(lk_kind),
      .lk_data(lk_data),
      .lk_busy(lk_busy),
      .lk_rdata(lk_rdata),
      .lk_rvalid(lk_rvalid),
      .cmd_valid(cmd_valid),
      .cmd_kind(cmd_kind),
      .cmd_data(cmd_data),
      .cmd_done(c.done),
      .cmd_rdata(c.rdata)
   );

   // all bank behaviour; outputs are registered copies of the next state
   always_comb
   begin
      logic spi_mode;
      logic two_wire_sel;
      logic wr_clr;
      logic clr_on_read;
      logic clr_on_write;
      logic [7:0] wrap_addr;
      logic [3:0] flags;
      logic [15:0] z_fmt;
      spi_mode = 1'b0;
      two_wire_sel = 1'b0;
      wr_clr = 1'b0;
      clr_on_read = 1'b0;
      clr_on_write = 1'b0;
      wrap_addr = `FCR_WRAP_AT_DATA;
      flags = 4'h0;
      z_fmt = 16'h0000;

      nxt_c = c;
      nxt_c.done = 1'b0;
      nxt_c.clr = 1'b0;
      nxt_c.advance = 1'b0;
      nxt_c.rearm = 1'b0;
      nxt_c.ext_trig = 1'b0;

      // pin synchronisers; the strap is taken from the second stage, the trigger edge from the second and third
      nxt_c.strap_s1 = host_is_spi_pin;
      nxt_c.strap_s2 = c.strap_s1;
      nxt_c.trig_s1 = int_pin_in;
      nxt_c.trig_s2 = c.trig_s1;
      nxt_c.trig_s3 = c.trig_s2;
      nxt_c.mode_d = sniff_while_awake_mode;
      nxt_c.flag_d = sniff_awake_event_flag;

      // clearing method follows the interface the host actually uses
      spi_mode = c.strap_s2;
      two_wire_sel = c.ifc[`FCR_IFC_TWO_WIRE_SEL];
      wr_clr = c.ftc[`FCR_FTC_WRITE_TO_CLEAR];
      clr_on_read = !spi_mode && !(wr_clr && two_wire_sel);
      clr_on_write = spi_mode || (wr_clr && two_wire_sel);
      wrap_addr = c.ftc[`FCR_FTC_WRAP_SEL] ? `FCR_WRAP_AT_STATUS : `FCR_WRAP_AT_DATA;

      flags = {interrupt_pending_flag, fifo_level_reached_flag, fifo_full, fifo_empty};
      z_fmt = fcr_fmt_z(z_sample_output, c.ftc[`FCR_FTC_FIFO_TOKEN], res_ge14, flags);

      // one command per cmd_valid, answered on the next edge
      if (cmd_valid)
      begin
         nxt_c.done = 1'b1;
         nxt_c.rdata = 8'h00;
         unique case (cmd_kind)
            FCR_CMD_START:
            begin
               nxt_c.addr = cmd_data;
               nxt_c.grp = 6'h00;
               nxt_c.in_txn = 1'b1;
            end
            FCR_CMD_WRITE:
            begin
               // low three bits are kept at zero whatever the host sends
               if (c.addr == `FCR_ADDR_IFC)
                  nxt_c.ifc = cmd_data & `FCR_IFC_WRITE_MASK;
               else if (c.addr == `FCR_ADDR_FTC)
                  nxt_c.ftc = cmd_data;
               if ((c.addr == `FCR_ADDR_STATUS_2) && clr_on_write)
                  nxt_c.clr = 1'b1;
               nxt_c.addr = c.addr + 8'h01;
            end
            FCR_CMD_READ:
            begin
               nxt_c.rdata = fcr_pick(c.addr, x_sample_output, y_sample_output, z_fmt,
                                      status_1, status_2, c.ifc, c.ftc);
               if ((c.addr == `FCR_ADDR_STATUS_2) && clr_on_read)
                  nxt_c.clr = 1'b1;
               if (c.addr == wrap_addr)
               begin
                  nxt_c.addr = `FCR_ADDR_DATA_FIRST;
                  // a finished group pops the fifo once, or per group in burst up to FIFO_DEPTH groups
                  if ((c.grp == 6'h00) ||
                      (c.ftc[`FCR_FTC_FIFO_BURST] && (c.grp < 6'(FIFO_DEPTH))))
                  begin
                     nxt_c.advance = 1'b1;
                     nxt_c.grp = c.grp + 6'h01;
                  end
               end
               else
                  nxt_c.addr = c.addr + 8'h01;
            end
            FCR_CMD_END:
            begin
               // select and wiring changes wait for the boundary
               nxt_c.in_txn = 1'b0;
               nxt_c.eff = c.ifc[7:5];
            end
            default:
            begin
               nxt_c.in_txn = c.in_txn;
            end
         endcase
      end

      // sniff detector: clear first, so a new event in the same cycle wins
      if (nxt_c.clr && c.ifc[`FCR_IFC_REARM_ON_CLEAR] && c.halted)
      begin
         nxt_c.halted = 1'b0;
         nxt_c.rearm = 1'b1;
      end
      if (fcr_edge(sniff_while_awake_mode, c.mode_d, 1'b0) && c.halted)
      begin
         nxt_c.halted = 1'b0;
         nxt_c.rearm = 1'b1;
      end
      if (fcr_edge(sniff_awake_event_flag, c.flag_d, 1'b1))
         nxt_c.halted = 1'b1;

      // external trigger on the chosen edge of the interrupt pin
      if (c.ftc[`FCR_FTC_EXTERNAL_TRIGGER_ENABLE] &&
          fcr_edge(c.trig_s2, c.trig_s3, c.ftc[`FCR_FTC_TRIG_EDGE]))
         nxt_c.ext_trig = 1'b1;

      // interface steering from the effective copy only
      nxt_c.store_en = nxt_c.eff[2] | nxt_c.eff[1];
      nxt_c.i2c_en = ~nxt_c.eff[2];
      nxt_c.spi_en = ~nxt_c.eff[1];
      nxt_c.three_w = nxt_c.eff[0];
      // token only makes sense on a separate data out line
      nxt_c.tok_en = spi_mode & ~nxt_c.eff[0] & nxt_c.ftc[`FCR_FTC_SPI_TOKEN];
      nxt_c.stat_byte = status_1;

      // fifo steering; freeze holds the samples that caused the event
      nxt_c.cap_en = ~(nxt_c.ifc[`FCR_IFC_FREEZE] & sniff_awake_event_flag);
      nxt_c.overwrite = nxt_c.ftc[`FCR_FTC_STREAM] & fifo_enabled;
      nxt_c.accept = nxt_c.cap_en & (~fifo_full | nxt_c.overwrite);
      nxt_c.zword = z_fmt;

      // pin is released while it serves as trigger input
      nxt_c.int_oe = ~nxt_c.ftc[`FCR_FTC_EXTERNAL_TRIGGER_ENABLE];
      nxt_c.int_out = interrupt_pending_flag & ~nxt_c.ftc[`FCR_FTC_EXTERNAL_TRIGGER_ENABLE];
   end

   // bank registers
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         c <= '{ifc: `FCR_IFC_RESET, ftc: `FCR_FTC_RESET, addr: `FCR_ADDR_DATA_FIRST,
                i2c_en: 1'b1, spi_en: 1'b1, cap_en: 1'b1, accept: 1'b1, int_oe: 1'b1,
                default: '0};
      else
         c <= nxt_c;
   end

   // outputs straight from the state record
   assign interface_feature_control = c.ifc;
   assign fifo_trigger_feature_control = c.ftc;
   assign sample_store_enable = c.store_en;
   assign i2c_comm_enable = c.i2c_en;
   assign spi_comm_enable = c.spi_en;
   assign three_wire_select = c.three_w;
   assign spi_token_enable = c.tok_en;
   assign spi_token_byte = c.stat_byte;
   assign fifo_capture_enable = c.cap_en;
   assign fifo_overwrite_oldest = c.overwrite;
   assign fifo_accept_new = c.accept;
   assign fifo_advance = c.advance;
   assign z_fifo_word = c.zword;
   assign interrupt_clear = c.clr;
   assign sniff_halted = c.halted;
   assign sniff_rearm = c.rearm;
   assign ext_trigger = c.ext_trig;
   assign int_pin_out = c.int_out;
   assign int_pin_oe = c.int_oe;

endmodule // fcr_feature_regs

/* bench/fcr_checker.sv */
/*
 port checker of the feature register bank, mclk domain only.
 assumes it is bound to fcr_feature_regs.
*/
`timescale 1ns/100ps
module fcr_checker
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // inputs
   input wire logic int_pin_in,
   input wire logic fifo_enabled,
   input wire logic sniff_awake_event_flag,
   // outputs
   input wire logic [7:0] interface_feature_control,
   input wire logic [7:0] fifo_trigger_feature_control,
   input wire logic sample_store_enable,
   input wire logic i2c_comm_enable,
   input wire logic spi_comm_enable,
   input wire logic three_wire_select,
   input wire logic spi_token_enable,
   input wire logic fifo_capture_enable,
   input wire logic fifo_overwrite_oldest,
   input wire logic int_pin_oe,
   input wire logic sniff_halted,
   input wire logic sniff_rearm,
   input wire logic ext_trigger
);
   // short names of the two registers
   wire logic [7:0] ic = interface_feature_control;
   wire logic [7:0] fc = fifo_trigger_feature_control;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // pin edge of the chosen direction, then the pulse after the synchroniser
   sequence trig_edge_s;
      fc[7] && (fc[6] ? $rose(int_pin_in) : $fell(int_pin_in));
   endsequence
   sequence trig_pulse_s;
      ##[2:5] ext_trigger;
   endsequence
   low_bits_zero_a: assert property (ic[2:0] == 3'h0) else $error("low bits set");
   select_steer_a: assert property (sample_store_enable ==
      (!i2c_comm_enable || !spi_comm_enable)) else $error("steering mismatch");
   freeze_cap_a: assert property (fifo_capture_enable ==
      !(ic[3] && $past(sniff_awake_event_flag))) else $error("capture wrong");
   stream_mode_a: assert property (fifo_overwrite_oldest ==
      (fc[5] && $past(fifo_enabled))) else $error("overwrite wrong");
   pin_dir_a: assert property (int_pin_oe == !fc[7]) else $error("pin dir");
   token_gate_a: assert property (spi_token_enable |->
      !three_wire_select && fc[2]) else $error("token in wrong mode");
   trig_edge_a: assert property (trig_edge_s |-> trig_pulse_s) else $error("no trig");
   sniff_halt_a: assert property ($rose(sniff_awake_event_flag) |->
      ##[1:2] sniff_halted) else $error("sniff not halted");
   rearm_cause_a: assert property (sniff_rearm |-> $past(sniff_halted))
      else $error("rearm while armed");
endmodule // fcr_checker

bind fcr_feature_regs fcr_checker fcr_checker_i (.*);

/* bench/fcr_host_model.sv */
/*
 serial front end model on the link clock: one command at a time.
 assumes the caller waits for each answer before the next command.
*/
`timescale 1ns/100ps
module fcr_host_model
   import fcr_pkg::*;
(
   // link clock
   input wire logic link_clk,
   // requests
   output logic lk_req,
   output fcr_cmd_t lk_kind,
   output logic [7:0] lk_data,
   // answers
   input wire logic lk_busy,
   input wire logic [7:0] lk_rdata,
   input wire logic lk_rvalid
);
   // idle at time zero
   initial
   begin
      lk_req = 1'b0;
      lk_kind = FCR_CMD_END;
      lk_data = 8'ha5;
   end
   // request held to the taking edge, answer taken at its own edge
   task automatic cmd(input fcr_cmd_t k, input logic [7:0] d, output logic [7:0] r,
      output bit to);
      int n;
      @(posedge link_clk);
      lk_req <= 1'b1;
      lk_kind <= k;
      lk_data <= d;
      @(posedge link_clk);
      to = (lk_busy !== 1'b0);
      lk_req <= 1'b0;
      lk_data <= ~d; // stale data must not pass for valid
      r = 8'h00;
      for (n = 0; n < 20 && !to; n++)
      begin
         @(posedge link_clk);
         if (lk_rvalid === 1'b1)
         begin
            r = lk_rdata;
            break;
         end
      end
      to = to || (n == 20);
   endtask
endmodule // fcr_host_model

/* bench/fcr_feature_regs_tb.sv */
/*
 testbench of the feature register bank: commands through the host model,
 pins and sample inputs driven here. assumes design, checker, model compiled.
*/
`timescale 1ns/100ps
module fcr_feature_regs_tb
   import fcr_pkg::*;
;
   logic mclk, link_clk, reset, lk_req, lk_busy, lk_rvalid, host_is_spi_pin, int_pin_in;
   fcr_cmd_t lk_kind;
   logic [7:0] lk_data, lk_rdata, status_1, status_2, spi_token_byte, rb, rv;
   logic [7:0] interface_feature_control, fifo_trigger_feature_control;
   logic [15:0] x_sample_output, y_sample_output, z_sample_output, z_fifo_word;
   logic res_ge14, interrupt_pending_flag, fifo_level_reached_flag, fifo_full, fifo_empty;
   logic fifo_enabled, sniff_while_awake_mode, sniff_awake_event_flag, int_pin_out, int_pin_oe;
   logic sample_store_enable, i2c_comm_enable, spi_comm_enable, three_wire_select;
   logic spi_token_enable, fifo_capture_enable, fifo_overwrite_oldest, fifo_accept_new;
   logic fifo_advance, interrupt_clear, sniff_halted, sniff_rearm, ext_trigger;
   logic [7:0] t_ifc [4] = '{8'h40, 8'h40, 8'h00, 8'h80};
   logic [7:0] t_ftc [4] = '{8'h00, 8'h10, 8'h10, 8'h10};
   int compares = 0, miscompares = 0, clr_n = 0, adv_n = 0, trg_n = 0, c;

   fcr_feature_regs #(.FIFO_DEPTH(8)) fcr_feature_regs_i (.*);
   fcr_host_model fcr_host_model_i (.*);

   // clocks, unrelated in phase
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial
   begin
      link_clk = 1'b0;
      #7;
      forever #15 link_clk = ~link_clk;
   end
   // pulse counters, since pulses last one mclk
   always @(posedge mclk)
   begin
      clr_n += interrupt_clear;
      adv_n += fifo_advance;
      trg_n += ext_trigger;
   end

   task automatic print_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      compares++;
      if (s !== e)
      begin
         miscompares++;
         $display("FAIL %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic xfer(input fcr_cmd_t k, input logic [7:0] d);
      bit to;
      fcr_host_model_i.cmd(k, d, rb, to);
      if (to)
      begin
         miscompares++;
         print_verdict();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(FCR_CMD_START, a);
      xfer(FCR_CMD_WRITE, d);
      xfer(FCR_CMD_END, 8'h00);
   endtask
   task automatic rd(input logic [7:0] a);
      xfer(FCR_CMD_START, a);
      xfer(FCR_CMD_READ, 8'h00);
      rv = rb;
      xfer(FCR_CMD_END, 8'h00);
   endtask
   task automatic settle;
      repeat (6) @(posedge mclk);
   endtask
   // expected byte at a data or status address, little-endian words
   function automatic logic [7:0] eb(input logic [7:0] a);
      logic [15:0] w;
      w = (a < 8'h04) ? x_sample_output : (a < 8'h06) ? y_sample_output : z_sample_output;
      if (a > 8'h07)
         return (a == 8'h08) ? status_1 : status_2;
      return a[0] ? w[15:8] : w[7:0];
   endfunction
   // burst read from the first data address, counting fifo pops
   task automatic burst(input logic [7:0] f, input int n, input int adv);
      logic [7:0] a;
      int p;
      wr(8'h0e, f);
      p = adv_n;
      a = 8'h02;
      xfer(FCR_CMD_START, 8'h02);
      repeat (n)
      begin
         xfer(FCR_CMD_READ, 8'h00);
         chk(16'(rb), 16'(eb(a)));
         a = (a == (f[0] ? 8'h09 : 8'h07)) ? 8'h02 : a + 8'h01;
      end
      xfer(FCR_CMD_END, 8'h00);
      chk(16'(adv_n - p), 16'(adv));
   endtask

   initial
   begin
      reset = 1'b1;
      {host_is_spi_pin, res_ge14, fifo_enabled, sniff_while_awake_mode} = 4'h0;
      {interrupt_pending_flag, fifo_level_reached_flag, fifo_full, fifo_empty} = 4'h0;
      {int_pin_in, sniff_awake_event_flag} = 2'h2;
      x_sample_output = 16'h8a71;
      y_sample_output = 16'h52c3;
      z_sample_output = 16'h1234;
      status_1 = 8'h9e;
      status_2 = 8'h65;
      repeat (3) @(posedge link_clk);
      @(posedge mclk) reset <= 1'b0;
      repeat (3) @(posedge link_clk);
      // reset values, then a select change held back to the end command
      rd(8'h0d);
      chk(16'(rv), 16'h0);
      rd(8'h0e);
      chk(16'(rv), 16'h0);
      chk(16'(sample_store_enable), 16'h0);
      xfer(FCR_CMD_START, 8'h0d);
      xfer(FCR_CMD_WRITE, 8'h47);
      settle();
      chk(16'(spi_comm_enable), 16'h1);
      xfer(FCR_CMD_END, 8'h00);
      settle();
      chk(16'(spi_comm_enable), 16'h0);
      chk(16'(sample_store_enable), 16'h1);
      rd(8'h0d);
      chk(16'(rv), 16'h40);
      $display("test interface select done");
      // status token only in four-wire spi
      @(posedge mclk) host_is_spi_pin <= 1'b1;
      wr(8'h0d, 8'ha0);
      wr(8'h0e, 8'h04);
      settle();
      chk(16'(three_wire_select), 16'h1);
      chk(16'(i2c_comm_enable), 16'h0);
      chk(16'(spi_token_enable), 16'h0);
      wr(8'h0d, 8'h80);
      settle();
      chk(16'(spi_token_enable), 16'h1);
      chk(16'(spi_token_byte), 16'(status_1));
      $display("test spi token done");
      // interrupt clearing per interface and write-to-clear
      for (int i = 0; i < 4; i++)
      begin
         @(posedge mclk) host_is_spi_pin <= (i == 3);
         wr(8'h0d, t_ifc[i]);
         wr(8'h0e, t_ftc[i]);
         c = clr_n;
         rd(8'h09);
         chk(16'(rv), 16'(status_2));
         chk(16'(clr_n - c), {15'h0, !i[0]});
         c = clr_n;
         wr(8'h09, 8'h5a);
         chk(16'(clr_n - c), {15'h0, i[0]});
      end
      $display("test interrupt clear done");
      @(posedge mclk) host_is_spi_pin <= 1'b0;
      wr(8'h0d, 8'h40);
      burst(8'h00, 12, 1);
      burst(8'h01, 10, 1);
      burst(8'h02, 60, 8);
      $display("test burst done");
      wr(8'h0e, 8'h08);
      @(posedge mclk) {interrupt_pending_flag, fifo_level_reached_flag, fifo_full} <= 3'h5;
      settle();
      chk(z_fifo_word, {4'ha, z_sample_output[11:0]});
      @(posedge mclk) res_ge14 <= 1'b1;
      settle();
      chk(z_fifo_word, {z_sample_output[15:4], 4'ha});
      $display("test fifo token done");
      // freeze, stream and sniff re-arm
      wr(8'h0d, 8'h58);
      wr(8'h0e, 8'h20);
      @(posedge mclk) {fifo_enabled, sniff_while_awake_mode, sniff_awake_event_flag} <= 3'h7;
      settle();
      chk(16'(fifo_overwrite_oldest), 16'h1);
      chk(16'(fifo_accept_new), 16'h0);
      chk(16'(sniff_halted), 16'h1);
      rd(8'h09);
      settle();
      chk(16'(sniff_halted), 16'h0);
      wr(8'h0d, 8'h48);
      @(posedge mclk) sniff_awake_event_flag <= 1'b0;
      settle();
      @(posedge mclk) sniff_awake_event_flag <= 1'b1;
      settle();
      rd(8'h09);
      settle();
      chk(16'(sniff_halted), 16'h1);
      @(posedge mclk) sniff_while_awake_mode <= 1'b0;
      settle();
      chk(16'(sniff_halted), 16'h0);
      wr(8'h0d, 8'h40);
      settle();
      chk(16'(fifo_capture_enable), 16'h1);
      $display("test sniff done");
      // one trigger per pass of three pin levels (two edges falling, three rising), chosen direction only
      for (int e = 0; e < 2; e++)
      begin
         wr(8'h0e, e[0] ? 8'hc0 : 8'h80);
         settle();
         chk(16'({int_pin_oe, int_pin_out}), 16'h0);
         c = trg_n;
         for (int j = 0; j < 3; j++)
         begin
            @(posedge mclk) int_pin_in <= e[0] ^ !j[0];
            settle();
         end
         chk(16'(trg_n - c), 16'h1);
      end
      $display("test trigger done");
      print_verdict();
   end
endmodule // fcr_feature_regs_tb
